// *** rtl/bss_map.svh ***
// Timing counts and threshold values for the buck startup sequencer.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH

// System clock and switching rate
`define BSS_CLK_HZ 100000000
`define BSS_FSW_HZ 600000
`define BSS_PERIOD_CYC (`BSS_CLK_HZ / `BSS_FSW_HZ)

// Largest high-side share of a period, in percent (rounded down)
`define BSS_DMAX_PCT 95
`define BSS_DMAX_CYC (`BSS_PERIOD_CYC * `BSS_DMAX_PCT / 100)

// Current-limit blanking at start of each high-side on-time (least time)
`define BSS_BLANK_NS 100
`define BSS_BLANK_CYC ((`BSS_BLANK_NS * (`BSS_CLK_HZ / 1000000) + 999) / 1000)

// Soft-start slope: 0.25 V/ms, i.e. 250 mV per ms, one mV per step
`define BSS_SS_SLOPE_MV_PER_MS 250
`define BSS_SS_STEP_CYC (`BSS_CLK_HZ / 1000 / `BSS_SS_SLOPE_MV_PER_MS)

// Full-scale reference and its soft-start period (6.0 ms)
`define BSS_SS_FULL_MV 1500
`define BSS_SS_FULL_MS 6

// Calibration time, 1.5 ms
`define BSS_CAL_US 1500
`define BSS_CAL_CYC (`BSS_CAL_US * (`BSS_CLK_HZ / 1000000))

// Hiccup timeout in full soft-start periods, and fault count limit
`define BSS_FAULT_PERIODS 7
`define BSS_TMO_STEPS (`BSS_FAULT_PERIODS * `BSS_SS_FULL_MV)
`define BSS_FAULT_LIMIT 7

// Low-side on-time growth per switching cycle during ramp-in
`define BSS_SR_STEP_CYC 8

// Short-circuit thresholds in mV
`define BSS_SCL_DEFAULT_MV 180
`define BSS_SCL_LOW_MV 105
`define BSS_SCL_HIGH_MV 310

`endif

// *** rtl/bss_pkg.sv ***
// Types shared by the buck startup sequencer files.
// No other package is assumed.
package bss_pkg;

   // Sequencer states, Gray coded along off-cal-ramp-run
   typedef enum logic [2:0] {
      BSS_OFF = 3'h0,
      BSS_CAL = 3'h1,
      BSS_SS = 3'h3,
      BSS_RUN = 3'h2,
      BSS_FAULT = 3'h6
   } bss_state_t;

   // Sensed compensation-pin current class during calibration
   typedef enum logic [1:0] {
      BSS_COMP_NONE = 2'h0,
      BSS_COMP_LOW_R = 2'h1,
      BSS_COMP_HIGH_R = 2'h2
   } bss_comp_t;

endpackage

// *** rtl/bss_gate_if.sv ***
// Carrier between the sequencer and its gate drive stage.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface bss_gate_if;
   logic hs_cmd; // High-side wanted
   logic ls_cmd; // Low-side wanted
   logic force_off; // Both drives off at once
   logic hs_off; // High-side gate sensed off
   logic ls_off; // Low-side gate sensed off
   logic hs_drv; // Registered high-side drive
   logic ls_drv; // Registered low-side drive

   modport seq (
      output hs_cmd,
      output ls_cmd,
      output force_off,
      output hs_off,
      output ls_off,
      input hs_drv,
      input ls_drv
   );

   modport drv (
      input hs_cmd,
      input ls_cmd,
      input force_off,
      input hs_off,
      input ls_off,
      output hs_drv,
      output ls_drv
   );
endinterface // bss_gate_if

// *** rtl/bss_gate_drive.sv ***
// Non-overlapping gate drive stage with adaptive dead time.
// Assumes gate-off sense inputs are synchronous to clk_sys.
`timescale 1ns/1ps
module bss_gate_drive (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   bss_gate_if.drv gate
);

   logic next_hs; // High-side next value
   logic next_ls; // Low-side next value

   // A side turns on only once the other is commanded off, no longer
   // driven, and sensed off at its gate; dead time is thus just the
   // real turn-off time plus one clock
   always_comb begin
      next_hs = gate.hs_cmd && !gate.ls_cmd && !gate.ls_drv
         && gate.ls_off && !gate.force_off;
      next_ls = gate.ls_cmd && !gate.hs_cmd && !gate.hs_drv
         && gate.hs_off && !gate.force_off;
   end

   // Drive registers, both low from reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gate.hs_drv <= 1'b0;
         gate.ls_drv <= 1'b0;
      end else if (clk_en) begin
         gate.hs_drv <= next_hs;
         gate.ls_drv <= next_ls;
      end
   end

endmodule // bss_gate_drive

// *** rtl/bss_sequencer.sv ***
// Startup, soft-start and fault sequencer of a synchronous buck
// controller, driving high-side and low-side gate commands.
// Assumes all analog comparator results arrive as synchronous bits
// on clk_sys, and that the reference input is a code in millivolts.
// Summary of operation
// - After calibration ramp reference, then hold it
// - Reference rises at fixed slope
// - Ramp time scales with external reference
// - Current limit active in ramp; seven trips
// - No rectification before first high-side pulse
// - Low-side on-time widens each cycle
// - No high-side pulse until ramp passes feedback
// - Low-side pulse ends before next high-side
// - Full two-quadrant rectification after startup
// - Low-side on at ramp end if overbiased
// - Blank comparator at high-side on-time start
// - Overcurrent ends present high-side pulse
// - Fault counter up after trip, else down
// - Count seven: fault, both drives off
// - Timeout seven soft-start periods, then restart
// - Calibration picks threshold from sensed current
// - Latch threshold, release sensing, start ramp
// - Gate drives never overlap, short dead time
// - Turn on after other gate sensed off
// - Calibrate first, then soft-start
// - Cap duty so bootstrap recharges
// - Lockout stops oscillator, drives low
// - Overtemperature stops all, restarts normally
`timescale 1ns/1ps
`include "bss_map.svh"
module bss_sequencer #(
   parameter int unsigned CAL_CYCLES = `BSS_CAL_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic enable_n,
   input wire logic undervoltage_lockout,
   input wire logic thermal_shutdown,
   input wire logic pwm_request,
   input wire logic overcurrent_pulse,
   input wire logic soft_start_above_feedback,
   input wire logic [1:0] comp_current_class,
   input wire logic [10:0] external_reference_input,
   input wire logic high_side_gate_off,
   input wire logic low_side_gate_off,
   output logic high_side_gate_drive,
   output logic low_side_gate_drive,
   output logic [10:0] soft_start_reference,
   output logic [8:0] short_circuit_limit,
   output logic calibration_sense_connect,
   output logic oscillator_run,
   output logic fault_active,
   output logic startup_done
);

   // Period and window constants at the widths they meet
   localparam logic [7:0] PER_LAST = 8'(`BSS_PERIOD_CYC - 1);
   localparam logic [7:0] DMAX = 8'(`BSS_DMAX_CYC);
   localparam logic [7:0] BLANK = 8'(`BSS_BLANK_CYC);
   localparam logic [8:0] STEP_LAST = 9'(`BSS_SS_STEP_CYC - 1);
   localparam logic [13:0] TMO_LAST = 14'(`BSS_TMO_STEPS - 1);
   localparam logic [2:0] FLIMIT = 3'(`BSS_FAULT_LIMIT);
   localparam logic [7:0] SR_STEP = 8'(`BSS_SR_STEP_CYC);
   localparam logic [17:0] CAL_LAST = 18'(CAL_CYCLES - 1);

   // Threshold decode from the sensed current class
   function automatic logic [8:0] limit_of(input logic [1:0] cls);
      logic [8:0] mv;
      mv = 9'(`BSS_SCL_DEFAULT_MV);
      if (cls == bss_pkg::BSS_COMP_LOW_R) begin
         mv = 9'(`BSS_SCL_LOW_MV);
      end else if (cls == bss_pkg::BSS_COMP_HIGH_R) begin
         mv = 9'(`BSS_SCL_HIGH_MV);
      end
      return mv;
   endfunction

   bss_pkg::bss_state_t state; // Sequencer state
   bss_pkg::bss_state_t next_state; // Its next value
   logic [7:0] phase; // Position in switching period
   logic cycle_end; // Last clock of the period
   logic [17:0] cal_cnt; // Calibration clock counter
   logic cal_end; // Calibration time complete
   logic [8:0] step_cnt; // Clocks within one 1 mV step
   logic step_tick; // One soft-start step elapsed
   logic [13:0] tmo_cnt; // Timeout steps elapsed
   logic tmo_end; // Hiccup timeout complete
   logic ramp_done; // Reference reached external level
   logic [2:0] fault_cnt; // Up/down fault counter
   logic fault_hit; // Counter has reached the limit
   logic [7:0] hs_on_cnt; // Clocks since high-side turned on
   logic oc_valid; // Trip seen outside blanking
   logic oc_seen; // Trip seen this period
   logic hs_allowed; // State permits high-side pulses
   logic pulses_seen; // First high-side pulse happened
   logic sr_full; // Full complementary rectification
   logic [7:0] sr_width; // Ramp-in low-side on-time
   logic hs_cmd; // High-side command to drive stage
   logic ls_cmd; // Low-side command to drive stage

   bss_gate_if gate ();

   // Oscillator runs only without lockout or overtemperature
   assign oscillator_run = !undervoltage_lockout
      && !thermal_shutdown;
   assign cycle_end = (phase == PER_LAST);
   assign cal_end = (cal_cnt == CAL_LAST);
   assign step_tick = (step_cnt == STEP_LAST);
   assign tmo_end = step_tick && (tmo_cnt == TMO_LAST);
   assign ramp_done = (soft_start_reference
      >= external_reference_input);
   assign fault_hit = (fault_cnt == FLIMIT);

   // Status outputs decoded from the state register
   assign calibration_sense_connect =
      (state == bss_pkg::BSS_CAL);
   assign fault_active = (state == bss_pkg::BSS_FAULT);
   assign startup_done = (state == bss_pkg::BSS_RUN);

   // Switching period counter; held at zero when stopped so the
   // first period after a restart is a whole one
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 8'h00;
      end else if (clk_en) begin
         if (!oscillator_run) begin
            phase <= 8'h00;
         end else if (cycle_end) begin
            phase <= 8'h00;
         end else begin
            phase <= phase + 8'h01;
         end
      end
   end

   // Next state; stop conditions take priority over all else
   always_comb begin
      next_state = state;
      case (state)
         bss_pkg::BSS_OFF: begin
            next_state = bss_pkg::BSS_CAL;
         end
         bss_pkg::BSS_CAL: begin
            if (cal_end) begin
               next_state = bss_pkg::BSS_SS;
            end
         end
         bss_pkg::BSS_SS: begin
            if (fault_hit) begin
               next_state = bss_pkg::BSS_FAULT;
            end else if (ramp_done) begin
               next_state = bss_pkg::BSS_RUN;
            end
         end
         bss_pkg::BSS_RUN: begin
            if (fault_hit) begin
               next_state = bss_pkg::BSS_FAULT;
            end
         end
         bss_pkg::BSS_FAULT: begin
            if (tmo_end) begin
               next_state = bss_pkg::BSS_CAL;
            end
         end
         default: begin
            next_state = bss_pkg::BSS_OFF;
         end
      endcase
      if (enable_n || !oscillator_run) begin
         next_state = bss_pkg::BSS_OFF;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= bss_pkg::BSS_OFF;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Calibration timer, restarted on every entry
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cal_cnt <= 18'h0_0000;
      end else if (clk_en) begin
         if (state == bss_pkg::BSS_CAL && !cal_end) begin
            cal_cnt <= cal_cnt + 18'h0_0001;
         end else begin
            cal_cnt <= 18'h0_0000;
         end
      end
   end

   // Threshold latched once at the end of calibration and held
   // through ramp, run and fault; a later sense change has no effect
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         short_circuit_limit <= 9'(`BSS_SCL_DEFAULT_MV);
      end else if (clk_en) begin
         if (state == bss_pkg::BSS_CAL && cal_end) begin
            short_circuit_limit <=
               limit_of(comp_current_class);
         end
      end
   end

   // Step timer shared by the ramp and the hiccup timeout
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         step_cnt <= 9'h000;
      end else if (clk_en) begin
         if (state != bss_pkg::BSS_SS
               && state != bss_pkg::BSS_FAULT) begin
            step_cnt <= 9'h000;
         end else if (step_tick) begin
            step_cnt <= 9'h000;
         end else begin
            step_cnt <= step_cnt + 9'h001;
         end
      end
   end

   // Soft-start reference: 1 mV per step regardless of the target,
   // so ramp time is proportional to the external reference
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         soft_start_reference <= 11'h000;
      end else if (clk_en) begin
         case (state)
            bss_pkg::BSS_SS: begin
               if (step_tick && !ramp_done) begin
                  soft_start_reference <=
                     soft_start_reference + 11'h001;
               end
            end
            bss_pkg::BSS_RUN: begin
               soft_start_reference <=
                  external_reference_input;
            end
            default: begin
               soft_start_reference <= 11'h000;
            end
         endcase
      end
   end

   // Hiccup timeout: seven full-scale soft-start periods
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tmo_cnt <= 14'h0000;
      end else if (clk_en) begin
         if (state != bss_pkg::BSS_FAULT) begin
            tmo_cnt <= 14'h0000;
         end else if (step_tick && !tmo_end) begin
            tmo_cnt <= tmo_cnt + 14'h0001;
         end
      end
   end

   // Clocks since the high-side drive went on, for blanking
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hs_on_cnt <= 8'h00;
      end else if (clk_en) begin
         if (!high_side_gate_drive) begin
            hs_on_cnt <= 8'h00;
         end else if (hs_on_cnt != BLANK) begin
            hs_on_cnt <= hs_on_cnt + 8'h01;
         end
      end
   end

   // Trip counts only while the switch is fully on past blanking
   assign oc_valid = overcurrent_pulse && high_side_gate_drive
      && (hs_on_cnt == BLANK);

   // Per-period trip flag; a trip on the last clock still counts
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         oc_seen <= 1'b0;
      end else if (clk_en) begin
         if (cycle_end) begin
            oc_seen <= 1'b0;
         end else if (oc_valid) begin
            oc_seen <= 1'b1;
         end
      end
   end

   // Fault counter: one step per switching period, up after a trip
   // and down otherwise; cleared at each new startup
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fault_cnt <= 3'h0;
      end else if (clk_en) begin
         if (state == bss_pkg::BSS_OFF
               || state == bss_pkg::BSS_CAL) begin
            fault_cnt <= 3'h0;
         end else if (state == bss_pkg::BSS_FAULT) begin
            fault_cnt <= fault_cnt; // Held until restart
         end else if (cycle_end) begin
            if (oc_seen || oc_valid) begin
               if (!fault_hit) begin
                  fault_cnt <= fault_cnt + 3'h1;
               end
            end else if (fault_cnt != 3'h0) begin
               fault_cnt <= fault_cnt - 3'h1;
            end
         end
      end
   end

   // A pre-biased output blocks pulses until the ramp passes it
   assign hs_allowed = (state == bss_pkg::BSS_RUN)
      || (state == bss_pkg::BSS_SS
         && soft_start_above_feedback);

   // Marks the first high-side pulse of the ramp
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulses_seen <= 1'b0;
      end else if (clk_en) begin
         if (state != bss_pkg::BSS_SS
               && state != bss_pkg::BSS_RUN) begin
            pulses_seen <= 1'b0;
         end else if (high_side_gate_drive) begin
            pulses_seen <= 1'b1;
         end
      end
   end

   // Low-side ramp-in width grows by a step each period after the
   // first pulse; run state forces full rectification
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sr_width <= 8'h00;
         sr_full <= 1'b0;
      end else if (clk_en) begin
         if (state == bss_pkg::BSS_RUN) begin
            sr_full <= 1'b1;
         end else if (state != bss_pkg::BSS_SS) begin
            sr_width <= 8'h00;
            sr_full <= 1'b0;
         end else if (cycle_end && pulses_seen && !sr_full) begin
            if (sr_width >= PER_LAST - SR_STEP) begin
               sr_full <= 1'b1;
            end else begin
               sr_width <= sr_width + SR_STEP;
            end
         end
      end
   end

   // High-side command: duty capped so the bootstrap recharges,
   // cut at once on a trip or when the counter hits the limit
   always_comb begin
      hs_cmd = hs_allowed && pwm_request
         && (phase < DMAX)
         && !oc_seen && !oc_valid
         && !fault_hit;
   end

   // Low-side command: off before the first pulse, then a pulse
   // whose leading edge moves earlier and which ends before the
   // next period starts, then the full complement of high-side
   always_comb begin
      ls_cmd = 1'b0;
      if (state == bss_pkg::BSS_RUN
            || (state == bss_pkg::BSS_SS && sr_full)) begin
         ls_cmd = !hs_cmd;
      end else if (state == bss_pkg::BSS_SS && pulses_seen) begin
         ls_cmd = !hs_cmd && (phase < PER_LAST)
            && (phase >= PER_LAST - sr_width);
      end else begin
         ls_cmd = 1'b0;
      end
   end

   // Hand the commands and gate sensing to the drive stage
   assign gate.hs_cmd = hs_cmd;
   assign gate.ls_cmd = ls_cmd;
   assign gate.hs_off = high_side_gate_off;
   assign gate.ls_off = low_side_gate_off;
   // Outside ramp and run both drives stay low
   assign gate.force_off = (state != bss_pkg::BSS_SS
      && state != bss_pkg::BSS_RUN)
      || fault_hit;

   bss_gate_drive u_drive (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .gate(gate.drv)
   );

   // Drive outputs come straight from the stage's registers
   assign high_side_gate_drive = gate.hs_drv;
   assign low_side_gate_drive = gate.ls_drv;

endmodule // bss_sequencer

// *** tb/bss_sequencer_props.sv ***
// Concurrent checks on the buck startup sequencer top ports.
// Assumes one clock domain; bound to bss_sequencer at the foot.
`timescale 1ns/1ps
module bss_sequencer_props #(
   parameter int unsigned CAL_CYCLES = 150000 // Matches the design
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic undervoltage_lockout,
   input wire logic thermal_shutdown,
   input wire logic overcurrent_pulse,
   input wire logic soft_start_above_feedback,
   input wire logic [10:0] external_reference_input,
   input wire logic high_side_gate_off,
   input wire logic low_side_gate_off,
   input wire logic high_side_gate_drive,
   input wire logic low_side_gate_drive,
   input wire logic [10:0] soft_start_reference,
   input wire logic [8:0] short_circuit_limit,
   input wire logic calibration_sense_connect,
   input wire logic oscillator_run,
   input wire logic fault_active,
   input wire logic startup_done
);
   logic [3:0] hs_cnt; // High-side on-time, saturating

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // High-side on-time in clocks, saturating
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hs_cnt <= 4'h0;
      end else if (!high_side_gate_drive) begin
         hs_cnt <= 4'h0;
      end else if (hs_cnt != 4'hf) begin
         hs_cnt <= hs_cnt + 4'h1;
      end
   end

   no_overlap_a: assert property (
      !(high_side_gate_drive && low_side_gate_drive))
      else $error("overlap");
   hs_after_ls_a: assert property (
      $rose(high_side_gate_drive) |->
      $past(low_side_gate_off) && !$past(low_side_gate_drive))
      else $error("hs before ls off");
   ls_after_hs_a: assert property (
      $rose(low_side_gate_drive) |->
      $past(high_side_gate_off) && !$past(high_side_gate_drive))
      else $error("ls before hs off");
   oc_cut_a: assert property (
      overcurrent_pulse && hs_cnt >= 4'ha |-> ##[1:3] !high_side_gate_drive)
      else $error("trip not cut");
   fault_off_a: assert property (
      fault_active && $past(fault_active) |->
      !high_side_gate_drive && !low_side_gate_drive)
      else $error("drive in fault");
   lockout_off_a: assert property (
      undervoltage_lockout [*3] |-> !high_side_gate_drive &&
      !low_side_gate_drive && !calibration_sense_connect)
      else $error("lockout on");
   osc_stop_a: assert property (
      oscillator_run == !(undervoltage_lockout || thermal_shutdown))
      else $error("osc run");
   thermal_off_a: assert property (
      thermal_shutdown [*3] |-> !high_side_gate_drive &&
      !low_side_gate_drive && !startup_done && !fault_active)
      else $error("thermal on");
   limit_hold_a: assert property (
      !calibration_sense_connect && !$past(calibration_sense_connect)
      |-> $stable(short_circuit_limit))
      else $error("limit moved");
   ramp_step_a: assert property (
      $changed(soft_start_reference) && soft_start_reference != 11'h000
      && !fault_active |->
      soft_start_reference == $past(soft_start_reference) + 11'h001)
      else $error("ramp step");
   ref_hold_a: assert property (
      startup_done |-> soft_start_reference == external_reference_input)
      else $error("ref not held");
   prebias_a: assert property (
      !soft_start_above_feedback && !$past(soft_start_above_feedback)
      && !startup_done |-> !$rose(high_side_gate_drive))
      else $error("pulse below fb");
endmodule // bss_sequencer_props

bind bss_sequencer bss_sequencer_props #(.CAL_CYCLES(CAL_CYCLES)) props_u (.*);

// *** tb/bss_fet_model.sv ***
// Behavioural model of the external high-side and low-side switches.
// Assumes drive commands are synchronous to clk_sys.
`timescale 1ns/1ps
module bss_fet_model #(
   parameter int DLY = 2 // Gate discharge time in clocks, 1 to 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic high_side_gate_drive,
   input wire logic low_side_gate_drive,
   output logic high_side_gate_off,
   output logic low_side_gate_off
);
   logic [7:0] hs_hist; // Recent high-side drive samples
   logic [7:0] ls_hist; // Recent low-side drive samples

   // Gate charge history; a slow gate keeps the other side waiting
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hs_hist <= 8'h00;
         ls_hist <= 8'h00;
      end else begin
         hs_hist <= {hs_hist[6:0], high_side_gate_drive};
         ls_hist <= {ls_hist[6:0], low_side_gate_drive};
      end
   end

   // Sensed off only once low for DLY clocks
   assign high_side_gate_off = !high_side_gate_drive &&
      (hs_hist[DLY-1:0] == '0);
   assign low_side_gate_off = !low_side_gate_drive &&
      (ls_hist[DLY-1:0] == '0);
endmodule // bss_fet_model

// *** tb/test_buck_startup_fault_sequencer.sv ***
// Self-checking bench for the buck startup and fault sequencer.
// Assumes the switch model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_buck_startup_fault_sequencer;
   localparam int CAL = 200; // Shortened calibration
   localparam int PER = 166; // Switching period in clocks
   localparam int STEP = 400; // Clocks per ramp millivolt
   localparam logic [10:0] EXT = 11'h064; // 100 mV keeps the ramp short
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic enable_n = 1'b1;
   logic uvlo = 1'b0;
   logic thermal = 1'b0;
   logic pwm_en = 1'b0; // Lets the modulator pattern through
   logic pwm_request = 1'b0;
   logic oc = 1'b0;
   logic ssaf = 1'b0;
   logic [1:0] cls = 2'h0;
   logic [7:0] pcnt = 8'h00; // Modulator phase
   logic hs_off, ls_off, hs, ls, sense, osc, fault, done;
   logic [10:0] ref_mv;
   logic [8:0] limit;
   int err_total = 0;
   int checked = 0;

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   // Modulator stand-in: high for the first 60 clocks of each period
   always @(posedge clk_sys) begin
      pcnt <= (pcnt == 8'ha5) ? 8'h00 : pcnt + 8'h01;
      pwm_request <= pwm_en && (pcnt < 8'h3c);
   end

   bss_sequencer #(.CAL_CYCLES(CAL)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
      .enable_n(enable_n), .undervoltage_lockout(uvlo),
      .thermal_shutdown(thermal), .pwm_request(pwm_request),
      .overcurrent_pulse(oc), .soft_start_above_feedback(ssaf),
      .comp_current_class(cls), .external_reference_input(EXT),
      .high_side_gate_off(hs_off), .low_side_gate_off(ls_off),
      .high_side_gate_drive(hs), .low_side_gate_drive(ls),
      .soft_start_reference(ref_mv), .short_circuit_limit(limit),
      .calibration_sense_connect(sense), .oscillator_run(osc),
      .fault_active(fault), .startup_done(done)
   );

   // Slow gates, so the adaptive dead time really waits
   bss_fet_model #(.DLY(3)) fet_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .high_side_gate_drive(hs),
      .low_side_gate_drive(ls), .high_side_gate_off(hs_off),
      .low_side_gate_off(ls_off)
   );

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Reset, then enable; returns one edge into calibration
   task automatic restart(input logic [1:0] c);
      step(1);
      rst_n <= 1'b0;
      enable_n <= 1'b1;
      cls <= c;
      step(3);
      #1 chk(limit, 9'h0b4);
      step(1);
      rst_n <= 1'b1;
      step(4);
      #1 chk(sense, 1'b0);
      step(1);
      enable_n <= 1'b0;
      step(1);
      #1 chk(sense, 1'b1);
   endtask

   // Every class picks its threshold, latched at calibration end
   task automatic t_cal();
      logic [8:0] lim [4] = '{9'h0b4, 9'h069, 9'h136, 9'h0b4};
      for (int i = 0; i < 4; i++) begin
         restart(2'(i));
         step(CAL - 1);
         #1 chk(sense, 1'b1);
         step(1);
         #1 chk(sense, 1'b0);
         chk(limit, lim[i]);
         step(1);
         cls <= 2'(i + 1);
         step(20);
         #1 chk(limit, lim[i]);
      end
   endtask

   // Pre-biased start, rectifier ramp-in, ramp length, pull-down
   task automatic t_ramp();
      int n = 0;
      int on = 0;
      logic [10:0] r0;
      int w [6] = '{default: 0};
      pwm_en <= 1'b1;
      restart(2'h0);
      step(CAL - 1);
      #1 r0 = ref_mv;
      repeat (10 * STEP) begin
         step(1);
         #1 on += int'(hs | ls);
         n++;
      end
      chk(16'(on), 16'h0000);
      chk(ref_mv - r0 >= 11'h009 && ref_mv - r0 <= 11'h00b, 1'b1);
      step(1);
      ssaf <= 1'b1;
      for (int p = 0; p < 6; p++) begin
         repeat (PER) begin
            step(1);
            #1 w[p] += int'(ls);
            n++;
         end
      end
      chk(w[5] > w[2], 1'b1);
      while (done !== 1'b1 && n < 50000) begin
         step(1);
         #1 n++;
      end
      chk(n >= int'(EXT) * STEP - STEP && n <= int'(EXT) * STEP + STEP,
         1'b1);
      chk(ref_mv, EXT);
      pwm_en <= 1'b0;
      step(12);
      #1 chk(ls, 1'b1);
      chk(hs, 1'b0);
   endtask

   // Persistent overcurrent in regulation leads to the hiccup timeout
   task automatic t_fault();
      int n = 0;
      int on = 0;
      pwm_en <= 1'b1;
      step(1);
      oc <= 1'b1;
      while (fault !== 1'b1 && n < 3000) begin
         step(1);
         #1 n++;
      end
      chk(n >= 6 * PER && n <= 9 * PER, 1'b1);
      repeat (500) begin
         step(1);
         #1 on += int'(hs | ls);
      end
      chk(16'(on), 16'h0000);
      chk(fault, 1'b1);
   endtask

   // Overtemperature and lockout stop everything; restart recalibrates
   task automatic t_lock();
      step(1);
      oc <= 1'b0;
      thermal <= 1'b1;
      #1 chk(osc, 1'b0);
      step(3);
      #1 chk(fault, 1'b0);
      chk(hs | ls, 1'b0);
      step(1);
      thermal <= 1'b0;
      step(2);
      #1 chk(sense, 1'b1);
      step(1);
      uvlo <= 1'b1;
      #1 chk(osc, 1'b0);
      step(3);
      #1 chk(sense | hs | ls, 1'b0);
      step(1);
      uvlo <= 1'b0;
   endtask

   initial begin
      t_cal();
      t_ramp();
      t_fault();
      t_lock();
      conclude();
   end

   // Run is ~43k clocks; allow 70k
   initial begin
      #700_000;
      err_total++;
      conclude();
   end
endmodule // test_buck_startup_fault_sequencer
